//--- design/asram_consts.vh
// timing and field constants for the async sram host controller
// assumes a 100 MHz clock; times in picoseconds, counts derived
`ifndef ASRAM_CONSTS_VH
`define ASRAM_CONSTS_VH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define ASRAM_CLK_PS              10000

// ----------------------------------------------------------------
// times in ps, fast grade then slow grade where the time has two grades
// ----------------------------------------------------------------
`define ASRAM_READ_CYCLE_MIN_F    45000
`define ASRAM_READ_CYCLE_MIN_S    55000
`define ASRAM_ADDR_ACCESS_MAX_F   45000
`define ASRAM_ADDR_ACCESS_MAX_S   55000
`define ASRAM_OUT_DRV_ACCESS_F    22000
`define ASRAM_OUT_DRV_ACCESS_S    25000
`define ASRAM_LANE_ACCESS_F       45000
`define ASRAM_LANE_ACCESS_S       55000
`define ASRAM_ADDR_WEND_MIN_F     35000
`define ASRAM_ADDR_WEND_MIN_S     40000
`define ASRAM_STROBE_WIDTH_F      35000
`define ASRAM_STROBE_WIDTH_S      40000
`define ASRAM_DATA_SETUP_MIN      25000
`define ASRAM_DATA_HOLD_MIN       0
`define ASRAM_STROBE_TURNOFF_F    18000
`define ASRAM_STROBE_TURNOFF_S    20000
`define ASRAM_BUS_TURNOFF_MAX     18000
`define ASRAM_RECOVERY_MIN_F      45000
`define ASRAM_RECOVERY_MIN_S      55000
`define ASRAM_DESEL_TO_RET_MIN    0

// ----------------------------------------------------------------
// cycle counts, rounded up, at least one
// ----------------------------------------------------------------
`define ASRAM_CYC(t) ((((t) + `ASRAM_CLK_PS - 1) / `ASRAM_CLK_PS) < 1 ? 1 : \
    (((t) + `ASRAM_CLK_PS - 1) / `ASRAM_CLK_PS))

// ----------------------------------------------------------------
// fields and counter width
// ----------------------------------------------------------------
`define ASRAM_LANE_LO             0
`define ASRAM_LANE_HI             1
`define ASRAM_CNT_W               4

`endif

//--- design/asram_ctrl.v
// host controller driving an asynchronous 16-bit static memory
// assumes synchronous request inputs and one 100 MHz clock
//
// Function
// R1 - write only while strobe, selects, lane active
// R2 - data stable 25ns before, 0ns after end
// R3 - address stable 35/40ns before write end
// R4 - write may start with address, change after
// R5 - strobe and lane low 35/40ns before end
// R6 - read data valid 45/55ns after address
// R7 - old read data held 10ns after change
// R8 - data valid 22/25ns after output enable
// R9 - lane data valid 45/55ns after lane
// R10 - strobe write pulse covers turnoff plus setup
// R11 - deselected by selects or both lanes off
// R12 - wait one read cycle after retention exit
// R13 - retention may start right at deselect
// R14 - select true when low-active low, high-active high
// R15 - device bus released when deselected or disabled
// R16 - write strobe high through every read
// R17 - count timings in whole cycles, rounded up
// R18 - never drive bus while device may drive
`include "asram_consts.vh"
module asram_ctrl #(
    parameter SLOW_GRADE = 0,
    parameter AW         = 20,
    parameter DW         = 16
) (
    // clock and reset
    input  wire          i_clk,
    input  wire          i_nrst,
    // user request
    input  wire          i_req,
    input  wire          i_wr,
    input  wire [AW-1:0] i_addr,
    input  wire [DW-1:0] i_wdata,
    input  wire [1:0]    i_lane,
    input  wire          i_retain,
    output reg           o_busy,
    output reg           o_done,
    output reg  [DW-1:0] o_rdata,
    output reg           o_rerr,
    output reg           o_in_retention,
    // memory pins
    output reg  [AW-1:0] o_addr,
    output reg           o_select_low_active_n,
    output reg           o_select_high_active,
    output reg           o_write_n,
    output reg           o_out_drive_n,
    output reg           o_upper_lane_enable_n,
    output reg           o_lower_lane_enable_n,
    output reg  [DW-1:0] o_dq,
    output reg           o_dq_oe,
    input  wire [DW-1:0] i_dq,
    input  wire          i_err
);

// ----------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------
localparam CW = `ASRAM_CNT_W;
localparam integer RD_T = SLOW_GRADE ? `ASRAM_ADDR_ACCESS_MAX_S
                                     : `ASRAM_ADDR_ACCESS_MAX_F;
localparam integer PW_T = SLOW_GRADE ? `ASRAM_STROBE_WIDTH_S
                                     : `ASRAM_STROBE_WIDTH_F;
localparam integer TO_T = SLOW_GRADE ? `ASRAM_STROBE_TURNOFF_S
                                     : `ASRAM_STROBE_TURNOFF_F;
localparam integer RC_T = SLOW_GRADE ? `ASRAM_RECOVERY_MIN_S
                                     : `ASRAM_RECOVERY_MIN_F;
localparam integer PW2_T = (TO_T + `ASRAM_DATA_SETUP_MIN) > PW_T ?
                           (TO_T + `ASRAM_DATA_SETUP_MIN) : PW_T;
localparam integer RD_N  = `ASRAM_CYC(RD_T) + 1;
localparam integer WR_N  = `ASRAM_CYC(PW2_T);
localparam integer TA_N  = `ASRAM_CYC(`ASRAM_BUS_TURNOFF_MAX);
localparam integer REC_N = `ASRAM_CYC(RC_T);
localparam [CW-1:0] RD_CYC  = RD_N[CW-1:0];                         // R17
localparam [CW-1:0] WR_CYC  = WR_N[CW-1:0];                         // R10
localparam [CW-1:0] TA_CYC  = TA_N[CW-1:0];                         // R18
localparam [CW-1:0] REC_CYC = REC_N[CW-1:0];                        // R12

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_RD   = 3'h1;
localparam [2:0] S_WR   = 3'h2;
localparam [2:0] S_TURN = 3'h3;
localparam [2:0] S_RET  = 3'h4;
localparam [2:0] S_REC  = 3'h5;

reg  [2:0]    state_r;
reg  [CW-1:0] cnt_r;
reg           cap_we_r;
wire [DW:0]   cap_q;

function [CW-1:0] dec;
    input [CW-1:0] v;
    begin
        dec = (v == {CW{1'b0}}) ? v : v - 1'b1;
    end
endfunction

// ----------------------------------------------------------------
// read capture register
// ----------------------------------------------------------------
asram_hold_reg #(.W(DW + 1)) u_hold (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_we   (cap_we_r),
    .i_d    ({i_err, i_dq}),
    .o_q    (cap_q)
);

always @*
begin
    o_rdata = cap_q[DW-1:0];
    o_rerr  = cap_q[DW];
end

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_nrst)
begin
    if (!i_nrst)
    begin
        state_r               <= S_IDLE;
        cnt_r                 <= {CW{1'b0}};
        cap_we_r              <= 1'b0;
        o_busy                <= 1'b0;
        o_done                <= 1'b0;
        o_in_retention        <= 1'b0;
        o_addr                <= {AW{1'b0}};
        o_select_low_active_n <= 1'b1;
        o_select_high_active  <= 1'b0;
        o_write_n             <= 1'b1;
        o_out_drive_n         <= 1'b1;
        o_upper_lane_enable_n <= 1'b1;
        o_lower_lane_enable_n <= 1'b1;
        o_dq                  <= {DW{1'b0}};
        o_dq_oe               <= 1'b0;
    end
    else
    begin
        o_done   <= 1'b0;
        cap_we_r <= 1'b0;
        cnt_r    <= dec(cnt_r);
        case (state_r)
        S_IDLE:
        begin
            if (i_retain)
            begin
                // deselected already, enter at once  R13 R11
                state_r        <= S_RET;
                o_in_retention <= 1'b1;
                o_busy         <= 1'b1;
            end
            else if (i_req && i_lane != 2'b00)
            begin
                o_busy                <= 1'b1;
                o_addr                <= i_addr;                 // R4
                o_select_low_active_n <= 1'b0;                   // R14
                o_select_high_active  <= 1'b1;                   // R14
                o_upper_lane_enable_n <= ~i_lane[`ASRAM_LANE_HI];
                o_lower_lane_enable_n <= ~i_lane[`ASRAM_LANE_LO];
                if (i_wr)
                begin
                    // strobe, data and address from one edge  R1 R3 R5
                    state_r       <= S_WR;
                    cnt_r         <= WR_CYC;
                    o_write_n     <= 1'b0;
                    o_out_drive_n <= 1'b1;                       // R18
                    o_dq          <= i_wdata;                    // R2
                    o_dq_oe       <= 1'b1;
                end
                else
                begin
                    state_r       <= S_RD;
                    cnt_r         <= RD_CYC;                     // R6 R8 R9
                    o_write_n     <= 1'b1;                       // R16
                    o_out_drive_n <= 1'b0;
                    o_dq_oe       <= 1'b0;                       // R18
                end
            end
        end
        S_RD:
        begin
            if (cnt_r == {{(CW-1){1'b0}}, 1'b1})
            begin
                cap_we_r <= 1'b1;                                // R7
            end
            if (cnt_r == {CW{1'b0}})
            begin
                // release device bus, then wait turnoff  R15 R18
                o_out_drive_n         <= 1'b1;
                o_select_low_active_n <= 1'b1;
                o_select_high_active  <= 1'b0;
                o_upper_lane_enable_n <= 1'b1;
                o_lower_lane_enable_n <= 1'b1;
                state_r               <= S_TURN;
                cnt_r                 <= TA_CYC;
            end
        end
        S_WR:
        begin
            if (cnt_r == {CW{1'b0}})
            begin
                // end write by strobe, selects and lanes together; data and address held  R1 R2 R4
                o_write_n             <= 1'b1;
                o_select_low_active_n <= 1'b1;
                o_select_high_active  <= 1'b0;
                o_upper_lane_enable_n <= 1'b1;
                o_lower_lane_enable_n <= 1'b1;
                state_r               <= S_TURN;
                cnt_r                 <= {{(CW-1){1'b0}}, 1'b1};
            end
        end
        S_TURN:
        begin
            o_dq_oe <= 1'b0;
            if (cnt_r == {CW{1'b0}})
            begin
                state_r <= S_IDLE;
                o_busy  <= 1'b0;
                o_done  <= 1'b1;
            end
        end
        S_RET:
        begin
            if (!i_retain)
            begin
                o_in_retention <= 1'b0;
                state_r        <= S_REC;
                cnt_r          <= REC_CYC;                       // R12
            end
        end
        S_REC:
        begin
            if (cnt_r == {CW{1'b0}})
            begin
                state_r <= S_IDLE;
                o_busy  <= 1'b0;
            end
        end
        default:
        begin
            state_r <= S_IDLE;
        end
        endcase
    end
end

endmodule

//--- design/asram_hold_reg.v
// holding register for captured read data and error flag
// assumes one clock, asynchronous active-low reset
module asram_hold_reg #(
    parameter W = 17
) (
    // clock and reset
    input  wire         i_clk,
    input  wire         i_nrst,
    // write side
    input  wire         i_we,
    input  wire [W-1:0] i_d,
    // read side
    output reg  [W-1:0] o_q
);

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_nrst)
begin
    if (!i_nrst)
        o_q <= {W{1'b0}};
    else if (i_we)
        o_q <= i_d;
end

endmodule

//--- tb/asram_ctrl_properties.sv
// pin timing checker for the async sram host controller
// assumes bind to asram_ctrl, one clock domain
module asram_chk #(parameter AW = 20) (
    input wire          i_clk,
    input wire          i_nrst,
    input wire          i_req,
    input wire          i_retain,
    input wire [1:0]    i_lane,
    input wire          o_busy,
    input wire          o_in_retention,
    input wire [AW-1:0] o_addr,
    input wire          o_write_n,
    input wire          o_out_drive_n,
    input wire          o_select_low_active_n,
    input wire          o_select_high_active,
    input wire [15:0]   o_dq,
    input wire          o_dq_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    rd_no_write_a: assert property (!o_out_drive_n |-> o_write_n)
        else $error("strobe low during read");
    no_contention_a: assert property (o_dq_oe |-> o_out_drive_n)
        else $error("host drives bus during read");
    strobe_width_a: assert property ($fell(o_write_n) |-> !o_write_n [*5])
        else $error("write strobe too short");
    write_stable_a: assert property (!o_write_n && !$past(o_write_n)
        |-> $stable(o_dq) && $stable(o_addr) && o_dq_oe)
        else $error("data or address moved in write");
    write_end_a: assert property ($rose(o_write_n) |-> o_dq_oe)
        else $error("data not held at write end");
    write_sel_a: assert property (!o_write_n |->
        !o_select_low_active_n && o_select_high_active)
        else $error("write without select");
    read_wait_a: assert property ($fell(o_out_drive_n)
        |-> !o_out_drive_n [*5])
        else $error("read closed too early");
    lane_ignore_a: assert property (i_req && i_lane == 2'b00 && !o_busy
        && !i_retain |=> !o_busy)
        else $error("empty lane request taken");
    recover_a: assert property ($fell(o_in_retention) |-> o_busy [*5])
        else $error("recovery too short");
endmodule
bind asram_ctrl asram_chk #(.AW(AW)) u_chk (.i_clk, .i_nrst, .i_req,
    .i_retain, .i_lane, .o_busy, .o_in_retention, .o_addr, .o_write_n,
    .o_out_drive_n, .o_select_low_active_n, .o_select_high_active,
    .o_dq, .o_dq_oe);

//--- tb/asram_ctrl_tb.sv
// self-checking bench for the async sram host controller
// assumes the memory model and the bound pin checker
module asram_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk, i_nrst, i_req, i_wr, i_retain;
    logic        o_busy, o_done, o_rerr, o_in_retention, o_dq_oe;
    logic        sl_n, sh, we_n, oe_n, ub_n, lb_n, m_drv, m_err;
    logic [19:0] i_addr, o_addr;
    logic [15:0] i_wdata, o_rdata, o_dq, m_dq;
    logic [1:0]  i_lane;
    int          n_mismatch, samples_checked, n;
    wire  [15:0] bus = o_dq_oe ? o_dq : m_dq;
    asram_ctrl u_asram_ctrl (.i_clk, .i_nrst, .i_req, .i_wr, .i_addr,
        .i_wdata, .i_lane, .i_retain, .o_busy, .o_done, .o_rdata, .o_rerr,
        .o_in_retention, .o_addr, .o_select_low_active_n(sl_n),
        .o_select_high_active(sh), .o_write_n(we_n), .o_out_drive_n(oe_n),
        .o_upper_lane_enable_n(ub_n), .o_lower_lane_enable_n(lb_n), .o_dq,
        .o_dq_oe, .i_dq(bus), .i_err(m_err));
    asram_mem_model u_asram_mem_model (.i_addr(o_addr),
        .i_select_low_active_n(sl_n), .i_select_high_active(sh),
        .i_write_n(we_n), .i_out_drive_n(oe_n), .i_upper_lane_enable_n(ub_n),
        .i_lower_lane_enable_n(lb_n), .i_dq(bus), .o_dq(m_dq), .o_err(m_err),
        .o_drive(m_drv));
    task give_verdict;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input bit ok);
        samples_checked++;
        if (!ok)
        begin
            n_mismatch++;
            $display("ERROR %0t unexpected value", $time);
        end
    endtask
    task acc(input bit wr, input [19:0] a, input [15:0] d, input [1:0] l);
        @(negedge i_clk);
        {i_req, i_wr, i_addr, i_wdata, i_lane} = {1'b1, wr, a, d, l};
        @(negedge i_clk);
        i_req = 1'b0;
        for (n = 0; o_done !== 1'b1 && n < 40; n++) @(negedge i_clk);
        chk(n < 40);
    endtask
    task rd(input [19:0] a, input [15:0] e, input [1:0] l);
        logic [15:0] m;
        m = {{8{l[1]}}, {8{l[0]}}};
        acc(1'b0, a, 16'h0000, l);
        chk((o_rdata & m) === (e & m));
        if (l == 2'b11) chk(o_rerr === ^e);
    endtask
    task t_reset;
        chk({sl_n, sh, we_n, oe_n, ub_n, lb_n, o_dq_oe, o_busy}
            === 8'b1011_1100);
    endtask
    task t_word;
        acc(1'b1, 20'h00005, 16'ha5c3, 2'b11);
        rd(20'h00005, 16'ha5c3, 2'b11);
        acc(1'b1, 20'h00006, 16'h5a3c, 2'b11);
        rd(20'h00006, 16'h5a3c, 2'b11);
    endtask
    task t_lane;
        acc(1'b1, 20'h00009, 16'h1234, 2'b11);
        acc(1'b1, 20'h00009, 16'hab00, 2'b10);
        acc(1'b1, 20'h00009, 16'h00cd, 2'b01);
        rd(20'h00009, 16'habcd, 2'b10);
        rd(20'h00009, 16'habcd, 2'b01);
        rd(20'h00009, 16'habcd, 2'b11);
    endtask
    task t_ignore;
        @(negedge i_clk);
        {i_req, i_wr, i_lane} = {1'b1, 1'b1, 2'b00};
        repeat (3) @(negedge i_clk);
        chk(o_busy === 1'b0 && we_n === 1'b1);
        i_req = 1'b0;
    endtask
    task t_ret;
        @(negedge i_clk);
        i_retain = 1'b1;
        repeat (4) @(negedge i_clk);
        chk(o_in_retention === 1'b1 && o_busy === 1'b1);
        i_retain = 1'b0;
        for (n = 0; o_busy !== 1'b0 && n < 40; n++) @(negedge i_clk);
        chk(n >= 5 && n < 40);
        rd(20'h00005, 16'ha5c3, 2'b11);
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(negedge i_clk)
        if (i_nrst && m_drv && o_dq_oe)
            chk(1'b0);
    initial
    begin
        #100000;
        n_mismatch++;
        $display("ERROR %0t watchdog expired", $time);
        give_verdict;
    end
    initial
    begin
        {i_req, i_wr, i_addr, i_wdata, i_lane, i_retain} = '0;
        i_nrst = 1'b0;
        repeat (16) @(negedge i_clk);
        t_reset;
        i_nrst = 1'b1;
        t_word;
        t_lane;
        t_ignore;
        t_ret;
        give_verdict;
    end
endmodule

//--- tb/asram_mem_model.sv
// behavioural async sram with byte lanes and error flag
// assumes the bench resolves the shared bus into i_dq
module asram_mem_model #(parameter SLOW = 0) (
    input  wire [19:0] i_addr,
    input  wire        i_select_low_active_n,
    input  wire        i_select_high_active,
    input  wire        i_write_n,
    input  wire        i_out_drive_n,
    input  wire        i_upper_lane_enable_n,
    input  wire        i_lower_lane_enable_n,
    input  wire [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic       o_err,
    output wire        o_drive
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int ACC = SLOW ? 55 : 45;
    localparam int OEA = SLOW ? 25 : 22;
    localparam int WMIN = SLOW ? 40 : 35;
    logic [15:0] mem [256];
    logic [15:0] w;
    logic [1:0]  lm;
    logic        v;
    time ta, to, tl, tw, td;
    wire sel = !i_select_low_active_n && i_select_high_active;
    wire on = sel && !(i_upper_lane_enable_n && i_lower_lane_enable_n);
    wire wact = on && !i_write_n;
    assign o_drive = on && i_write_n && !i_out_drive_n;
    always @(i_addr) ta = $time;
    always @(negedge i_out_drive_n) to = $time;
    always @(i_upper_lane_enable_n or i_lower_lane_enable_n) tl = $time;
    always @(i_dq) td = $time;
    always @(posedge wact)
    begin
        tw = $time;
        lm = {!i_upper_lane_enable_n, !i_lower_lane_enable_n};
    end
    always @(negedge wact)
    begin
        w = i_dq;
        if ($time-td < 25 || $time-ta < WMIN || $time-tw < WMIN)
            w = ~i_dq;
        if (lm[1]) mem[i_addr[7:0]][15:8] = w[15:8];
        if (lm[0]) mem[i_addr[7:0]][7:0] = w[7:0];
    end
    initial
    begin
        o_dq = 16'h0000;
        o_err = 1'b0;
        #0.5;
        forever
        begin
            #1;
            v = o_drive && $time-ta >= ACC && $time-to >= OEA
                && $time-tl >= ACC;
            w = v ? mem[i_addr[7:0]] : ~o_dq;
            if (i_upper_lane_enable_n) w[15:8] = ~o_dq[15:8];
            if (i_lower_lane_enable_n) w[7:0] = ~o_dq[7:0];
            if (!(o_drive && $time-ta < 10))
            begin
                o_dq = w;
                o_err = v ? ^mem[i_addr[7:0]] : ~o_err;
            end
        end
    end
endmodule
